/* File: hdl/ahpc_regs.svh */
// Constants of the converter host port: offsets, fields, reset values.
// Assumes a 20 MHz system clock and a 12-bit processor data bus.
// Function
// RL1: Soft reset bit restores both control registers
// RL2: Host writes zero to leave soft reset
// RL3: Writing sync bit resets sync generator
// RL4: Host sets sync bit for multichannel setup
// RL5: Host writes zeros to bits two to five
// RL6: Bit six set: write pin is direction
// RL7: Direction high reads, low writes
// RL8: Bit six clear: separate read, write pins
// RL9: Bit seven picks binary or twos complement
// RL10: Offset bit runs zero-input calibration conversion
// RL11: Stored offset subtracted from every result
// RL12: Bit nine enables control register readback
// RL13: Readback returns first, then second register
// RL14: Host clears debug bit to resume results; code resumes after second register word, bit nine set
// RL15: Read strobe on last valid, write idle
// RL16: Read strobe drops on first invalid
// RL17: Read strobe advances words, enables drivers
// RL18: Write strobe on last valid, read idle
// RL19: Write strobe drops on first invalid
// RL20: Write strobe latches word into register
// RL21: Second register words carry bits 01
// RL22: Low select and high select both needed
// RL23: Soft reset holds logic, takes only second
`ifndef AHPC_REGS_SVH
`define AHPC_REGS_SVH

`define AHPC_DATA_W 12
`define AHPC_SEL_MSB 11
`define AHPC_SEL_LSB 10
`define AHPC_SEL_CR0 2'h0
`define AHPC_SEL_CR1 2'h1
`define AHPC_CR0_RST 12'h020
`define AHPC_CR1_RST 10'h030
`define AHPC_CR1_W 10
`define AHPC_BIT_SOFT_RST 0
`define AHPC_BIT_SYNC_RST 1
`define AHPC_BIT_RW_MODE 6
`define AHPC_BIT_FORMAT 7
`define AHPC_BIT_OFFSET 8
`define AHPC_BIT_READBACK 9
`define AHPC_MSB 11
`define AHPC_ZERO 12'h000

`endif

/* File: hdl/ahpc_pkg.sv */
// Types of the converter host port.
// Assumes ahpc_regs.svh is on the include path.
`include "ahpc_regs.svh"

package ahpc_pkg;

  // Raw host pins, in pin polarity
  typedef struct packed {
    logic chip_select_low_n;
    logic chip_select_high;
    logic rd_n;
    logic wr_n;
  } ahpc_pins_t;

  // Converter result path toward the host port
  typedef struct packed {
    logic valid;
    logic [`AHPC_DATA_W-1:0] data;
  } ahpc_conv_t;

  typedef enum logic [1:0] {
    AHPC_RS_RESULT = 2'b00,
    AHPC_RS_CR0 = 2'b01,
    AHPC_RS_CR1 = 2'b10
  } ahpc_rd_state_t;

  typedef enum logic [1:0] {
    AHPC_CAL_IDLE = 2'b00,
    AHPC_CAL_WAIT = 2'b01,
    AHPC_CAL_DONE = 2'b10
  } ahpc_cal_state_t;

endpackage : ahpc_pkg

/* File: hdl/ahpc_top.sv */
// Host port of the converter: strobes, both control registers, output words.
// Assumes host pins are asynchronous to sys_clk_i and the result stream
// comes from logic on sys_clk_i in two's complement.
`include "ahpc_regs.svh"

module ahpc_top
  import ahpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Host pins
  input wire ahpc_pins_t host_pins_i,
  input wire logic [`AHPC_DATA_W-1:0] data_i,
  output logic [`AHPC_DATA_W-1:0] data_o,
  output logic data_oe_o,
  // Converter side
  input wire ahpc_conv_t conv_i,
  output logic force_zero_o,
  output logic sync_gen_reset_o,
  output logic soft_reset_o,
  output logic [`AHPC_DATA_W-1:0] ctrl_first_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  ahpc_pins_t pins_m_q;
  ahpc_pins_t pins_s_q;
  logic [`AHPC_DATA_W-1:0] data_m_q;
  logic [`AHPC_DATA_W-1:0] data_s_q;

  // Reset to the idle pin levels so no false strobe edge follows reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_m_q <= '{1'b1, 1'b0, 1'b1, 1'b1};
      pins_s_q <= '{1'b1, 1'b0, 1'b1, 1'b1};
    end else begin
      pins_m_q <= host_pins_i;
      pins_s_q <= pins_m_q;
    end
  end

  // Data rides the same two stages, aligned with the strobes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_m_q <= `AHPC_ZERO;
      data_s_q <= `AHPC_ZERO;
    end else begin
      data_m_q <= data_i;
      data_s_q <= data_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal strobes
  logic [`AHPC_DATA_W-1:0] cr0_q;
  logic [`AHPC_CR1_W-1:0] cr1_q;
  logic rd_stb_q;
  logic wr_stb_q;

  wire cs_ok = !pins_s_q.chip_select_low_n && pins_s_q.chip_select_high; // RL22
  wire rw_mode = cr1_q[`AHPC_BIT_RW_MODE];
  // Combined mode ignores the read pin entirely
  wire rd_act = rw_mode ? pins_s_q.wr_n : !pins_s_q.rd_n; // RL6 RL7 RL8
  wire wr_act = rw_mode ? !pins_s_q.wr_n : !pins_s_q.wr_n; // RL7 RL8
  wire rd_in_idle = rw_mode ? 1'b1 : pins_s_q.rd_n;
  wire rd_stb = cs_ok && rd_act && !(wr_act && !rw_mode); // RL15 RL16
  wire wr_stb = cs_ok && wr_act && rd_in_idle; // RL18 RL19
  wire rd_rise = rd_stb && !rd_stb_q;
  // Latch on the trailing edge: data is only promised valid before it
  wire wr_fall = wr_stb_q && !wr_stb;

  ////////////////////////////////////////////////////////////////////////
  // Register write decode
  // Target register of a bus word; both write paths decode it
  function automatic logic sel_hit(input logic [1:0] sel,
                                   input logic [1:0] code);
    return sel == code;
  endfunction : sel_hit

  // Codes 1x match neither register and are dropped
  wire [1:0] wsel = data_s_q[`AHPC_SEL_MSB:`AHPC_SEL_LSB];
  wire soft_rst = cr1_q[`AHPC_BIT_SOFT_RST];
  wire wr_cr1 = wr_fall && sel_hit(wsel, `AHPC_SEL_CR1); // RL20 RL21
  // First register is locked while soft reset holds
  wire wr_cr0 = wr_fall && sel_hit(wsel, `AHPC_SEL_CR0) &&
                !soft_rst; // RL20 RL23
  wire [`AHPC_CR1_W-1:0] wdat = data_s_q[`AHPC_CR1_W-1:0];
  wire new_soft = wdat[`AHPC_BIT_SOFT_RST];
  wire [`AHPC_CR1_W-1:0] cr1_rst_held = `AHPC_CR1_RST | {
    {(`AHPC_CR1_W-1){1'b0}}, 1'b1};

  logic [`AHPC_CR1_W-1:0] cr1_d;
  logic [`AHPC_DATA_W-1:0] cr0_d;

  always_comb begin
    cr1_d = cr1_q;
    cr0_d = cr0_q;
    if (wr_cr1 && new_soft) begin
      cr1_d = cr1_rst_held; // RL1
      cr0_d = `AHPC_CR0_RST; // RL1
    end else if (wr_cr1) begin
      cr1_d = wdat; // RL20
    end else if (wr_cr0) begin
      cr0_d = data_s_q; // RL20
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cr1_q <= `AHPC_CR1_RST;
      cr0_q <= `AHPC_CR0_RST;
    end else begin
      cr1_q <= cr1_d;
      cr0_q <= cr0_d;
    end
  end

  // Previous strobe levels for the edge detectors
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else begin
      rd_stb_q <= rd_stb;
      wr_stb_q <= wr_stb;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Offset calibration
  ahpc_cal_state_t cal_q;
  ahpc_cal_state_t cal_d;
  logic [`AHPC_DATA_W-1:0] offset_q;
  logic [`AHPC_DATA_W-1:0] offset_d;

  wire cal_start = wr_cr1 && !new_soft && wdat[`AHPC_BIT_OFFSET];

  always_comb begin
    cal_d = cal_q;
    offset_d = offset_q;
    case (cal_q)
      AHPC_CAL_IDLE: begin
        if (cal_start) begin
          cal_d = AHPC_CAL_WAIT; // RL10
        end
      end
      AHPC_CAL_WAIT: begin
        // Zeroed input converted once, kept as offset
        if (conv_i.valid) begin
          offset_d = conv_i.data; // RL10
          cal_d = AHPC_CAL_DONE;
        end
      end
      AHPC_CAL_DONE: begin
        if (cal_start) begin
          cal_d = AHPC_CAL_WAIT;
        end
      end
      default: begin
        cal_d = AHPC_CAL_IDLE;
      end
    endcase
    if (soft_rst) begin
      cal_d = AHPC_CAL_IDLE; // RL23
      offset_d = `AHPC_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result path
  logic [`AHPC_DATA_W-1:0] result_q;
  logic [`AHPC_DATA_W-1:0] result_d;
  wire [`AHPC_DATA_W-1:0] corrected = conv_i.data - offset_q; // RL11
  wire [`AHPC_DATA_W-1:0] flip_msb = {
    cr1_q[`AHPC_BIT_FORMAT], {(`AHPC_DATA_W-1){1'b0}}};
  wire take_result = conv_i.valid && (cal_q != AHPC_CAL_WAIT) && !soft_rst;

  // Straight binary is two's complement with the sign bit inverted
  assign result_d = soft_rst ? `AHPC_ZERO :
                    take_result ? (corrected ^ flip_msb) : result_q; // RL9

  ////////////////////////////////////////////////////////////////////////
  // Output word sequence
  ahpc_rd_state_t rs_q;
  ahpc_rd_state_t rs_d;
  logic [`AHPC_DATA_W-1:0] word;
  wire rb_on = cr1_q[`AHPC_BIT_READBACK];
  wire rb_arm = wr_cr1 && !new_soft && wdat[`AHPC_BIT_READBACK];
  wire [`AHPC_DATA_W-1:0] cr1_word = {`AHPC_SEL_CR1, cr1_q};

  always_comb begin
    rs_d = rs_q;
    word = result_q;
    case (rs_q)
      AHPC_RS_CR0: begin
        word = cr0_q; // RL13
        if (rd_rise) begin
          rs_d = AHPC_RS_CR1;
        end
      end
      AHPC_RS_CR1: begin
        word = cr1_word; // RL13
        if (rd_rise) begin
          rs_d = AHPC_RS_RESULT;
        end
      end
      default: begin
        word = result_q;
      end
    endcase
    if (rb_arm) begin
      rs_d = AHPC_RS_CR0; // RL12
    end else if (!rb_on || soft_rst) begin
      rs_d = AHPC_RS_RESULT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State and output registers
  logic [`AHPC_DATA_W-1:0] data_d;
  assign data_d = rd_rise ? word : data_o; // RL17

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_q <= AHPC_CAL_IDLE;
      offset_q <= `AHPC_ZERO;
    end else begin
      cal_q <= cal_d;
      offset_q <= offset_d;
    end
  end

  // Last corrected result, held until the next valid conversion taken outside calibration; zeroed in soft reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_q <= `AHPC_ZERO;
    end else begin
      result_q <= result_d;
    end
  end

  // Readback pointer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_q <= AHPC_RS_RESULT;
    end else begin
      rs_q <= rs_d;
    end
  end

  // Word and driver enable switch on the same edge
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_o <= `AHPC_ZERO;
      data_oe_o <= 1'b0;
    end else begin
      data_o <= data_d;
      data_oe_o <= rd_stb; // RL17
    end
  end

  // Converter side controls, taken from next values to save a cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_zero_o <= 1'b0;
      sync_gen_reset_o <= 1'b0;
      soft_reset_o <= 1'b0;
      ctrl_first_o <= `AHPC_CR0_RST;
    end else begin
      force_zero_o <= (cal_d == AHPC_CAL_WAIT); // RL10
      sync_gen_reset_o <= wr_cr1 && wdat[`AHPC_BIT_SYNC_RST]; // RL3
      soft_reset_o <= cr1_d[`AHPC_BIT_SOFT_RST]; // RL1 RL23
      ctrl_first_o <= cr0_d;
    end
  end

endmodule : ahpc_top

/* File: verification/ahpc_asserts.sv */
// Checker of the host port strobes and control outputs.
// Assumes one clock domain and an async active-high reset.
module ahpc_chk
  import ahpc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Host side
  input wire ahpc_pins_t host_pins_i,
  input wire logic [11:0] data_o,
  input wire logic data_oe_o,
  // Converter side
  input wire ahpc_conv_t conv_i,
  input wire logic force_zero_o,
  input wire logic sync_gen_reset_o,
  input wire logic soft_reset_o,
  input wire logic [11:0] ctrl_first_o
);
  wire logic sel_ok;
  assign sel_ok = !host_pins_i.chip_select_low_n &&
                  host_pins_i.chip_select_high;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Two sync flops plus the enable flop
  sequence sel_gone;
    !sel_ok [*4];
  endsequence
  AST_OE_CAUSE: assert property ($rose(data_oe_o) |-> $past(sel_ok, 2))
    else $error("Driver enable without selects");
  AST_OE_DROP: assert property (sel_gone |-> !data_oe_o)
    else $error("Driver enable outlived strobe");
  AST_DATA_LOAD: assert property ($changed(data_o) |-> $rose(data_oe_o))
    else $error("Output word moved outside read");
  AST_SYNC_PULSE: assert property (sync_gen_reset_o |=> !sync_gen_reset_o)
    else $error("Sync reset longer than a cycle");
  AST_SYNC_TRAIL: assert property (sync_gen_reset_o |-> !$past(sel_ok))
    else $error("Sync reset before write ended");
  AST_SOFT_CR0: assert property (soft_reset_o |-> ctrl_first_o == 12'h020)
    else $error("First register left reset value");
  AST_SOFT_CAL: assert property (soft_reset_o |-> !force_zero_o)
    else $error("Calibration ran in soft reset");
  AST_CAL_END: assert property (force_zero_o && conv_i.valid |=> !force_zero_o)
    else $error("Zero forcing outlived conversion");
  AST_CAL_STOP: assert property ($fell(force_zero_o) |-> $past(conv_i.valid) || soft_reset_o)
    else $error("Zero forcing ended early");
endmodule : ahpc_chk
////////////////////////////////////////////////////////////////////////////
bind ahpc_top ahpc_chk u_ahpc_chk (.*);

/* File: verification/ahpc_host.sv */
// Processor bus master model for the converter host port.
// Assumes tasks are entered just after a rising clock edge.
module ahpc_host
  import ahpc_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Host bus
  output ahpc_pins_t pins_o,
  output logic [11:0] bus_o,
  input wire logic [11:0] bus_i,
  input wire logic bus_oe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam ahpc_pins_t IdlePins = 4'hB;
  initial begin
    pins_o = IdlePins;
    bus_o = 12'h000;
  end
  // Second read pin level lets a test break separate mode
  task automatic wr(input logic [11:0] w, input logic rd_n);
    pins_o <= {1'h0, 1'h1, rd_n, 1'h0};
    bus_o <= w;
    repeat (4) @(posedge sys_clk_i);
    pins_o <= IdlePins;
    repeat (2) @(posedge sys_clk_i);
    bus_o <= ~w; // Released bus never keeps a stale word
    repeat (4) @(posedge sys_clk_i);
  endtask : wr
  // Both read pins active: a read in either pin scheme
  task automatic rd(output logic [11:0] w);
    int n;
    n = 0;
    pins_o <= 4'h5;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (bus_oe_i !== 1'h1 && n < 10);
    w = bus_i;
    pins_o <= IdlePins;
    repeat (4) @(posedge sys_clk_i);
  endtask : rd
endmodule : ahpc_host

/* File: verification/tb_top.sv */
// Self-checking bench of the converter host port.
// Assumes the host model holds every bus access.
module tb_top;
  import ahpc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rst_i, data_oe_o, force_zero_o;
  logic sync_gen_reset_o, soft_reset_o;
  logic [11:0] data_i, data_o, ctrl_first_o;
  ahpc_pins_t host_pins_i;
  ahpc_conv_t conv_i;
  int miscompares, checks, pulses;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h want %h", $time, a, e); end end
  ahpc_top u_ahpc_top (.*);
  ahpc_host u_ahpc_host (.sys_clk_i(sys_clk_i), .pins_o(host_pins_i),
    .bus_o(data_i), .bus_i(data_o), .bus_oe_i(data_oe_o));
  initial begin
    sys_clk_i = 1'h0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) if (sync_gen_reset_o === 1'h1) pulses++;
  task automatic cv(input logic [11:0] raw);
    conv_i <= {1'h1, raw};
    @(posedge sys_clk_i);
    conv_i <= '0;
    repeat (2) @(posedge sys_clk_i);
  endtask : cv
  task automatic rdx(input logic [11:0] e);
    logic [11:0] w;
    u_ahpc_host.rd(w);
    `CHK(w, e)
  endtask : rdx
  task automatic wr(input logic [11:0] w, input logic rd_n = 1'h1);
    u_ahpc_host.wr(w, rd_n);
  endtask : wr
  task automatic wrap_up;
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    rst_i = 1'h1;
    conv_i = '0;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    @(posedge sys_clk_i);
    `CHK(ctrl_first_o, 12'h020)
    wr(12'h600);
    rdx(12'h020);
    rdx(12'h600);
    wr(12'h402);
    `CHK(pulses, 1)
    wr(12'h155);
    `CHK(ctrl_first_o, 12'h155)
    $display("Test registers done");
    wr(12'h500);
    `CHK(force_zero_o, 1'h1)
    cv(12'h005);
    `CHK(force_zero_o, 1'h0)
    cv(12'h105);
    rdx(12'h100);
    wr(12'h480);
    cv(12'h105);
    rdx(12'h900);
    $display("Test results done");
    wr(12'h440);
    rdx(12'h900);
    wr(12'h0AA, 1'h0);
    `CHK(ctrl_first_o, 12'h0AA)
    wr(12'h400, 1'h0);
    wr(12'h033, 1'h0);
    `CHK(ctrl_first_o, 12'h0AA)
    $display("Test pin modes done");
    wr(12'h401);
    `CHK(soft_reset_o, 1'h1)
    wr(12'h0AA);
    `CHK(ctrl_first_o, 12'h020)
    wr(12'h400);
    `CHK(soft_reset_o, 1'h0)
    $display("Test soft reset done");
    wrap_up();
  end
  // About twenty times the expected run
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    miscompares++;
    wrap_up();
  end
endmodule : tb_top
